// [rtl/tmr_target.sv]
// tmr_target.sv: target end, decodes reset and clear allegiance requests
// assumes the task engine reports outstanding data requests and completions
`timescale 1ns/1ns
`default_nettype none
`include "tmr_regs.svh"
module tmr_target #(
  parameter int LUNS  = 8,
  parameter int INITS = 4
) (
  input  wire logic             i_mclk,
  input  wire logic             i_nrst,
  tmr_link_if.target            link,
  input  wire logic [7:0]       i_init_id,
  input  wire logic [LUNS-1:0]  i_lun_present,
  input  wire logic [LUNS-1:0]  i_aca_set,
  input  wire logic [LUNS-1:0]  i_data_pending,
  input  wire logic             i_status_busy,
  output logic [LUNS-1:0]       o_abort_lun,
  output logic [LUNS-1:0]       o_release_lun,
  output logic [LUNS-1:0]       o_mode_restore,
  output logic [LUNS-1:0]       o_flush_lun,
  output logic                  o_status_block,
  output logic [INITS*LUNS-1:0] o_aca,
  output logic [INITS-1:0]      o_unit_attention
);
  // elaboration check; unit and requester numbers are byte wide, and the unit
  // slice below needs a spare bit inside that byte
  if (LUNS < 1 || LUNS > 128 || INITS < 1 || INITS > 128) begin : g_size_check
    $error("tmr_target: LUNS and INITS must be 1..128");
  end

  typedef enum logic [2:0] {st_rx, st_flush, st_act, st_send, st_wait} tmr_state_type;
  tmr_state_type state;
  tmr_state_type next_state;

  logic [3:0]           cnt;
  logic                 bad;
  logic [7:0]           pcode;
  logic [15:0]          tag;
  logic [31:0]          path;
  logic [7:0]           lun;
  tmr_pkg::tmr_req_type kind;
  logic [7:0]           rcode;
  logic [LUNS-1:0]      scope;
  logic                 rx_done;
  logic                 lun_ok;
  logic                 b_busy;
  logic [INITS-1:0]     init_sel;

  // a target reset has no unit byte, so its frame is one byte shorter
  function automatic logic [3:0] req_len(input logic [7:0] pc);
    req_len = (pc == `TMR_PC_TGT_RESET) ? `TMR_REQ_LEN_TGT : `TMR_REQ_LEN_LU;
  endfunction : req_len

  // requests are stalled while one is being handled; no overlap possible
  assign link.req_ready = (state == st_rx);
  assign rx_done = link.req_valid && link.req_ready && cnt == req_len(pcode) - 4'h1
                   && cnt != 4'h0 && !(link.req_first && cnt != 4'h0);
  assign lun_ok  = (lun < 8'(LUNS)) && i_lun_present[lun[$clog2(LUNS+1)-1:0] % LUNS];
  assign init_sel = INITS'(1) << (i_init_id % 8'(INITS));

  // byte collection; a first marker restarts the frame
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt   <= 4'h0;
      bad   <= 1'b0;
      pcode <= 8'h00;
      tag   <= 16'h0000;
      path  <= 32'h00000000;
      lun   <= 8'h00;
    end else if (link.req_valid && link.req_ready) begin
      if (link.req_first) begin
        cnt <= 4'h1;
        bad <= (link.req_data != `TMR_MSG_CODE);
      end else begin
        cnt <= rx_done ? 4'h0 : cnt + 4'h1;
        case (cnt)
          `TMR_BYTE_PC:     pcode <= link.req_data;
          `TMR_BYTE_TAG_HI: tag[15:8] <= link.req_data;
          `TMR_BYTE_TAG_LO: tag[7:0]  <= link.req_data;
          `TMR_BYTE_LUN:    lun <= link.req_data;
          default: if (cnt >= `TMR_BYTE_PATH0 && cnt <= `TMR_BYTE_PATH3)
                     path <= {path[23:0], link.req_data};
        endcase
      end
    end
  end

  // decode once the frame is complete
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      kind <= tmr_pkg::tmr_req_none;
    end else if (rx_done) begin
      case (pcode)
        `TMR_PC_TGT_RESET: kind <= bad ? tmr_pkg::tmr_req_none : tmr_pkg::tmr_req_tgt_reset;
        `TMR_PC_CLR_ACA:   kind <= bad ? tmr_pkg::tmr_req_none : tmr_pkg::tmr_req_clr_aca;
        `TMR_PC_LU_RESET:  kind <= bad ? tmr_pkg::tmr_req_none : tmr_pkg::tmr_req_lu_reset;
        default:           kind <= tmr_pkg::tmr_req_none;
      endcase
    end
  end

  // target reset touches every unit, the others just the named one
  always_comb begin
    scope = '0;
    if (kind == tmr_pkg::tmr_req_tgt_reset)
      scope = '1;
    else if (lun_ok)
      scope[lun[$clog2(LUNS+1)-1:0] % LUNS] = 1'b1;
  end

  // gather, wait out data and status, act, answer; malformed or other frames are dropped
  always_comb begin
    next_state = state;
    case (state)
      st_rx:    if (rx_done) next_state = st_flush;
      st_flush: begin
        if (kind == tmr_pkg::tmr_req_none) next_state = st_rx;
        else if (kind != tmr_pkg::tmr_req_tgt_reset && !lun_ok) next_state = st_send;
        else if (kind == tmr_pkg::tmr_req_clr_aca) next_state = st_act;
        else if ((i_data_pending & scope) == '0 && !i_status_busy)
          next_state = st_act;
      end
      st_act:   next_state = st_send;
      st_send:  if (!b_busy) next_state = st_wait;
      st_wait:  if (!b_busy) next_state = st_rx;
      default:  next_state = st_rx;
    endcase
  end

  // state register
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) state <= st_rx;
    else         state <= next_state;
  end

  // flush requests while waiting; status is held off from the action to the end of the response, except on clear allegiance
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flush_lun    <= '0;
      o_status_block <= 1'b0;
    end else begin
      o_flush_lun    <= (state == st_flush && kind != tmr_pkg::tmr_req_clr_aca)
                        ? scope : '0;
      o_status_block <= (next_state == st_act || next_state == st_send
                         || next_state == st_wait) && kind != tmr_pkg::tmr_req_clr_aca;
    end
  end

  // one-cycle action pulses; init tables and alerts have no port here
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_abort_lun    <= '0;
      o_release_lun  <= '0;
      o_mode_restore <= '0;
    end else begin
      o_abort_lun    <= '0;
      o_release_lun  <= '0;
      o_mode_restore <= '0;
      if (state == st_act && kind != tmr_pkg::tmr_req_clr_aca) begin
        o_abort_lun    <= scope;
        o_release_lun  <= scope;
        o_mode_restore <= scope;
      end
    end
  end

  // allegiance table, set wins over clear; unit attention set for all on reset
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_aca            <= '0;
      o_unit_attention <= '0;
      rcode            <= `TMR_RC_SUCCESS;
    end else begin
      if (state == st_flush)
        rcode <= (kind == tmr_pkg::tmr_req_tgt_reset) ? `TMR_RC_SUCCESS
               : !lun_ok ? `TMR_RC_INVALID
               : (kind == tmr_pkg::tmr_req_clr_aca && !o_aca[(i_init_id % 8'(INITS))*LUNS
                  + (lun % 8'(LUNS))]) ? `TMR_RC_NO_ACA : `TMR_RC_SUCCESS;
      for (int i = 0; i < INITS; i++) begin
        for (int l = 0; l < LUNS; l++) begin
          if (state == st_act && kind != tmr_pkg::tmr_req_clr_aca && scope[l])
            o_aca[i*LUNS+l] <= 1'b0;
          if (state == st_act && kind == tmr_pkg::tmr_req_clr_aca && init_sel[i] && scope[l])
            o_aca[i*LUNS+l] <= 1'b0;
          if (i_aca_set[l] && init_sel[i])
            o_aca[i*LUNS+l] <= 1'b1;
        end
      end
      if (state == st_act && kind != tmr_pkg::tmr_req_clr_aca)
        o_unit_attention <= '1;
    end
  end

  tmr_rsp_builder u_rsp (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_start (state == st_send),
    .i_tag   (tag),
    .i_code  (rcode),
    .i_path  (path),
    .i_ready (link.rsp_ready),
    .o_valid (link.rsp_valid),
    .o_data  (link.rsp_data),
    .o_first (link.rsp_first),
    .o_path  (link.rsp_path),
    .o_busy  (b_busy)
  );
endmodule : tmr_target
`default_nettype wire

// [rtl/tmr_regs.svh]
// tmr_regs.svh: message codes, byte positions, return codes and frame lengths
// assumes message bytes arrive one at a time with a first-byte marker
// Contract
// - target reset aborts all, clears allegiance, reservations
// - resets restore saved modes, else defaults
// - resets leave tables, alerts, other protocols alone
// - initiator resets over every logical path used
// - initiator stops outbound data before reset
// - flush requested data before aborting tasks
// - status before response only, none after
// - reset sets unit attention for all initiators
// - target reset always answered with success
// - initiator drops aborted commands on response
// - target reset payload 83h 33h tag path
// - response sent on return path, tag pairs
// - clear allegiance only requester and named unit
// - clear allegiance payload 83h 34h tag path unit
// - bad unit answers invalid field, no action
// - clear allegiance returns success, none, or invalid
// - unit reset limited to named unit
// - unit reset payload 83h 35h tag path unit
// - response 83h 03h tag return code
// - return codes 00h 01h 04h 20h FFh
// - command answered only when fields invalid; the target answers every decoded request and drops malformed frames
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
`define TMR_MSG_CODE      8'h83
`define TMR_PC_TGT_RESET  8'h33
`define TMR_PC_CLR_ACA    8'h34
`define TMR_PC_LU_RESET   8'h35
`define TMR_PC_RESPONSE   8'h03
`define TMR_RC_SUCCESS    8'h00
`define TMR_RC_NOT_FOUND  8'h01
`define TMR_RC_OVERLAP    8'h04
`define TMR_RC_NO_ACA     8'h20
`define TMR_RC_INVALID    8'hff
`define TMR_REQ_LEN_TGT   4'h8
`define TMR_REQ_LEN_LU    4'h9
`define TMR_RSP_LEN       4'h5
`define TMR_BYTE_CODE     4'h0
`define TMR_BYTE_PC       4'h1
`define TMR_BYTE_TAG_HI   4'h2
`define TMR_BYTE_TAG_LO   4'h3
`define TMR_BYTE_PATH0    4'h4
`define TMR_BYTE_PATH1    4'h5
`define TMR_BYTE_PATH2    4'h6
`define TMR_BYTE_PATH3    4'h7
`define TMR_BYTE_LUN      4'h8
`define TMR_BYTE_RC       4'h4
`endif

// [rtl/tmr_pkg.sv]
// tmr_pkg.sv: shared types for the task management responder
// assumes tmr_regs.svh supplies the numeric codes
package tmr_pkg;
  typedef enum logic [1:0] {
    tmr_req_none,
    tmr_req_tgt_reset,
    tmr_req_clr_aca,
    tmr_req_lu_reset
  } tmr_req_type;
endpackage : tmr_pkg

// [rtl/tmr_link_if.sv]
// tmr_link_if.sv: byte link between initiator and target ends
// assumes one clock; a byte moves when valid and ready are both high
`timescale 1ns/1ns
`default_nettype none
interface tmr_link_if;
  logic        req_valid;
  logic        req_ready;
  logic [7:0]  req_data;
  logic        req_first;
  logic        rsp_valid;
  logic        rsp_ready;
  logic [7:0]  rsp_data;
  logic        rsp_first;
  logic [31:0] rsp_path;
  modport target (input req_valid, req_data, req_first, rsp_ready,
                  output req_ready, rsp_valid, rsp_data, rsp_first, rsp_path);
  modport initiator (output req_valid, req_data, req_first, rsp_ready,
                     input req_ready, rsp_valid, rsp_data, rsp_first, rsp_path);
endinterface : tmr_link_if
`default_nettype wire

// [rtl/tmr_rsp_builder.sv]
// tmr_rsp_builder.sv: serialises one response message onto the link
// assumes the loader pulses i_start only while o_busy is low
`timescale 1ns/1ns
`default_nettype none
`include "tmr_regs.svh"
module tmr_rsp_builder (
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic        i_start,
  input  wire logic [15:0] i_tag,
  input  wire logic [7:0]  i_code,
  input  wire logic [31:0] i_path,
  input  wire logic        i_ready,
  output logic             o_valid,
  output logic [7:0]       o_data,
  output logic             o_first,
  output logic [31:0]      o_path,
  output logic             o_busy
);
  logic [3:0]  idx;
  logic [15:0] tag;
  logic [7:0]  code;

  // byte picked by index, held in flip-flops below
  function automatic logic [7:0] rsp_byte(input logic [3:0] i,
                                          input logic [15:0] t,
                                          input logic [7:0] c);
    case (i)
      `TMR_BYTE_CODE:   rsp_byte = `TMR_MSG_CODE;
      `TMR_BYTE_PC:     rsp_byte = `TMR_PC_RESPONSE;
      `TMR_BYTE_TAG_HI: rsp_byte = t[15:8];
      `TMR_BYTE_TAG_LO: rsp_byte = t[7:0];
      default:          rsp_byte = c;
    endcase
  endfunction : rsp_byte

  // load on start, step one byte per accepted transfer
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy  <= 1'b0;
      o_valid <= 1'b0;
      idx     <= 4'h0;
      tag     <= 16'h0000;
      code    <= 8'h00;
      o_data  <= 8'h00;
      o_first <= 1'b0;
      o_path  <= 32'h00000000;
    end else if (i_start && !o_busy) begin
      o_busy  <= 1'b1;
      o_valid <= 1'b1;
      idx     <= 4'h1;
      tag     <= i_tag;
      code    <= i_code;
      o_path  <= i_path;
      o_first <= 1'b1;
      o_data  <= rsp_byte(`TMR_BYTE_CODE, i_tag, i_code);
    end else if (o_valid && i_ready) begin
      o_first <= 1'b0;
      if (idx == `TMR_RSP_LEN) begin
        o_valid <= 1'b0;
        o_busy  <= 1'b0;
      end else begin
        o_data <= rsp_byte(idx, tag, code);
        idx    <= idx + 4'h1;
      end
    end
  end
endmodule : tmr_rsp_builder
`default_nettype wire

// [rtl/tmr_initiator.sv]
// tmr_initiator.sv: initiator end, sends one request and collects its response
// assumes the user holds outbound data off before i_go, per path
`timescale 1ns/1ns
`default_nettype none
`include "tmr_regs.svh"
module tmr_initiator (
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  tmr_link_if.initiator    link,
  input  wire logic        i_go,
  input  wire logic [7:0]  i_pcode,
  input  wire logic [15:0] i_tag,
  input  wire logic [31:0] i_path,
  input  wire logic [7:0]  i_lun,
  output logic             o_busy,
  output logic             o_stop_data,
  output logic             o_done,
  output logic [15:0]      o_tag,
  output logic [7:0]       o_code,
  output logic             o_purge
);
  logic [3:0]  idx;
  logic [3:0]  ridx;
  logic [7:0]  pc;
  logic [15:0] tag;
  logic [31:0] path;
  logic [7:0]  lun;
  logic        in_rsp;

  function automatic logic [7:0] req_byte(input logic [3:0] i, input logic [7:0] p,
                                          input logic [15:0] t, input logic [31:0] r,
                                          input logic [7:0] u);
    case (i)
      `TMR_BYTE_CODE:   req_byte = `TMR_MSG_CODE;
      `TMR_BYTE_PC:     req_byte = p;
      `TMR_BYTE_TAG_HI: req_byte = t[15:8];
      `TMR_BYTE_TAG_LO: req_byte = t[7:0];
      `TMR_BYTE_PATH0:  req_byte = r[31:24];
      `TMR_BYTE_PATH1:  req_byte = r[23:16];
      `TMR_BYTE_PATH2:  req_byte = r[15:8];
      `TMR_BYTE_PATH3:  req_byte = r[7:0];
      default: req_byte = u;
    endcase
  endfunction : req_byte

  assign link.req_valid = o_busy && !in_rsp;
  assign link.req_first = (idx == `TMR_BYTE_CODE);
  assign link.req_data  = req_byte(idx, pc, tag, path, lun);
  assign link.rsp_ready = 1'b1;

  // send phase; the caller repeats per logical path in use
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy      <= 1'b0;
      in_rsp      <= 1'b0;
      idx         <= 4'h0;
      pc          <= 8'h00;
      tag         <= 16'h0000;
      path        <= 32'h00000000;
      lun         <= 8'h00;
      o_stop_data <= 1'b0;
    end else if (!o_busy) begin
      if (i_go) begin
        o_busy <= 1'b1;
        pc     <= i_pcode;
        tag    <= i_tag;
        path   <= i_path;
        lun    <= i_lun;
        idx <= 4'h0;
        o_stop_data <= 1'b1;
      end
    end else if (!in_rsp && link.req_ready) begin
      if (idx == ((pc == `TMR_PC_TGT_RESET) ? `TMR_REQ_LEN_TGT : `TMR_REQ_LEN_LU) - 4'h1)
        in_rsp <= 1'b1;
      else
        idx <= idx + 4'h1;
    end else if (o_done) begin
      o_busy      <= 1'b0;
      in_rsp      <= 1'b0;
      o_stop_data <= 1'b0;
    end
  end

  // response collection; purge aborted commands on a reset answer
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ridx    <= 4'h0;
      o_done  <= 1'b0;
      o_tag   <= 16'h0000;
      o_code  <= 8'h00;
      o_purge <= 1'b0;
    end else begin
      o_done  <= 1'b0;
      o_purge <= 1'b0;
      if (link.rsp_valid) begin
        ridx <= link.rsp_first ? 4'h1 : ridx + 4'h1;
        case (link.rsp_first ? 4'h0 : ridx)
          `TMR_BYTE_TAG_HI: o_tag[15:8] <= link.rsp_data;
          `TMR_BYTE_TAG_LO: o_tag[7:0]  <= link.rsp_data;
          `TMR_BYTE_RC: begin
            o_code  <= link.rsp_data;
            o_done  <= in_rsp && o_tag == tag;
            o_purge <= in_rsp && o_tag == tag && pc != `TMR_PC_CLR_ACA;
          end
          default: ;
        endcase
      end
    end
  end
endmodule : tmr_initiator
`default_nettype wire

// [tb/tmr_link_properties.sv]
// tmr_link_properties.sv: timing and framing checks on the request/response byte link
// assumes one clock; the initiator end takes every response byte at once
`timescale 1ns/1ns
`default_nettype none
module tmr_link_properties (
  input wire logic        i_mclk,
  input wire logic        i_nrst,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [7:0]  req_data,
  input wire logic        req_first,
  input wire logic        rsp_valid,
  input wire logic        rsp_ready,
  input wire logic [7:0]  rsp_data,
  input wire logic        rsp_first,
  input wire logic [31:0] rsp_path
);
  logic [3:0]  rq_cnt;
  logic [7:0]  rq_pc;
  logic [47:0] rq_fld;
  wire logic   rq_take = req_valid && req_ready;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // capture code, tag and path of the request; only one is open at a time
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rq_cnt <= 4'h0;
      rq_pc  <= 8'h00;
      rq_fld <= 48'h0;
    end else if (rq_take) begin
      rq_cnt <= req_first ? 4'h1 : rq_cnt + 4'h1;
      if (!req_first && rq_cnt == 4'h1) rq_pc <= req_data;
      if (!req_first && rq_cnt >= 4'h2 && rq_cnt <= 4'h7) rq_fld <= {rq_fld[39:0], req_data};
    end
  end
  sequence rsp_start;
    rsp_valid && rsp_first && rsp_ready;
  endsequence
  sequence rsp_head;
    rsp_data == 8'h83 ##1 rsp_valid && !rsp_first && rsp_data == 8'h03;
  endsequence
  sequence rsp_tag;
    ##2 rsp_data == rq_fld[47:40] ##1 rsp_data == rq_fld[39:32];
  endsequence
  req_open_a :
    assert property (req_valid && req_first |-> req_data == 8'h83)
      else $error("request not opened by message code");
  req_pcode_a :
    assert property (rq_take && req_first |=> req_valid && req_data inside {8'h33, 8'h34, 8'h35})
      else $error("request protocol code unknown");
  rsp_head_a :
    assert property (rsp_start |-> rsp_head)
      else $error("response header bytes wrong");
  rsp_len_a :
    assert property (rsp_start |-> ##1 rsp_valid [*4] ##1 !rsp_valid)
      else $error("response length not five bytes");
  rsp_tag_a :
    assert property (rsp_start |-> rsp_tag)
      else $error("response tag differs from request");
  rsp_path_a :
    assert property (rsp_valid |-> rsp_path == rq_fld[31:0])
      else $error("response path differs from request");
  rc_set_a :
    assert property (rsp_start |-> ##4 rsp_data inside {8'h00, 8'h20, 8'hff})
      else $error("return code outside allowed set");
  tgt_ok_a :
    assert property (rsp_start and rq_pc == 8'h33 |-> ##4 rsp_data == 8'h00)
      else $error("target reset not answered with success");
  reply_a :
    assert property (rq_take && (rq_cnt == 4'h8 || (rq_cnt == 4'h7 && rq_pc == 8'h33))
                     |-> ##[3:300] rsp_valid && rsp_first)
      else $error("request left without response");
endmodule : tmr_link_properties
`default_nettype wire

// [tb/testbench.sv]
// testbench.sv: initiator and target ends back to back, driven from their user sides
// assumes the initiator raises o_done once the last response byte is in
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        i_mclk  = 1'b0;
  logic        i_nrst  = 1'b0;
  logic        go      = 1'b0;
  logic [7:0]  pcode   = 8'h00;
  logic [15:0] tag     = 16'h0000;
  logic [31:0] path    = 32'h0;
  logic [7:0]  lun     = 8'h00;
  logic [7:0]  init_id = 8'h00;
  logic [7:0]  present = 8'h7f;
  logic [7:0]  aca_set = 8'h00;
  logic [7:0]  pend    = 8'h00;
  logic        sbusy   = 1'b0;
  wire logic [7:0]  abort_lun, release_lun, mode_restore, flush_lun, rcode;
  wire logic [31:0] aca;
  wire logic [15:0] rtag;
  wire logic [3:0]  ua;
  wire logic        st_block, busy, stop_data, done, purge;
  logic [7:0]  ab, rl, md, rb [0:7], qb [0:15];
  logic        dn, pg, sd, sb;
  logic [31:0] rpath;
  int          rbn = 0;
  int          qbn = 0;
  int          err_count = 0;
  int          total_checks = 0;
  always #50 i_mclk = ~i_mclk;
  tmr_link_if lk ();
  tmr_target #(.LUNS(8), .INITS(4)) u_tmr_target (.i_mclk(i_mclk), .i_nrst(i_nrst), .link(lk),
    .i_init_id(init_id), .i_lun_present(present), .i_aca_set(aca_set), .i_data_pending(pend),
    .i_status_busy(sbusy), .o_abort_lun(abort_lun), .o_release_lun(release_lun),
    .o_mode_restore(mode_restore), .o_flush_lun(flush_lun), .o_status_block(st_block),
    .o_aca(aca), .o_unit_attention(ua));
  tmr_initiator u_tmr_initiator (.i_mclk(i_mclk), .i_nrst(i_nrst), .link(lk), .i_go(go),
    .i_pcode(pcode), .i_tag(tag), .i_path(path), .i_lun(lun), .o_busy(busy),
    .o_stop_data(stop_data), .o_done(done), .o_tag(rtag), .o_code(rcode), .o_purge(purge));
  tmr_link_properties u_tmr_link_properties (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .req_valid(lk.req_valid), .req_ready(lk.req_ready), .req_data(lk.req_data),
    .req_first(lk.req_first), .rsp_valid(lk.rsp_valid), .rsp_ready(lk.rsp_ready),
    .rsp_data(lk.rsp_data), .rsp_first(lk.rsp_first), .rsp_path(lk.rsp_path));
  // record bytes as they cross the wire, so byte order is judged on the link itself
  always @(posedge i_mclk) begin
    if (lk.rsp_valid && lk.rsp_ready) begin
      if (lk.rsp_first) rbn = 0;
      if (lk.rsp_first) rpath = lk.rsp_path;
      if (rbn < 8) rb[rbn] = lk.rsp_data;
      rbn = rbn + 1;
    end
    if (lk.req_valid && lk.req_ready) begin
      if (lk.req_first) qbn = 0;
      if (qbn < 16) qb[qbn] = lk.req_data;
      qbn = qbn + 1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic aca_pulse(input logic [7:0] id, input logic [7:0] m);
    @(posedge i_mclk);
    init_id <= id;
    aca_set <= m;
    @(posedge i_mclk);
    aca_set <= 8'h00;
  endtask : aca_pulse
  // one request, response compared on the wire and at the initiator's user side
  task automatic run(input logic [7:0] pc, input logic [7:0] ln, input logic [7:0] rc,
                     input logic [15:0] tg, input logic [31:0] pt);
    int n;
    @(posedge i_mclk);
    go <= 1'b1;
    pcode <= pc;
    tag <= tg;
    path <= pt;
    lun <= ln;
    {ab, rl, md, dn, pg, sd, sb} = 28'h0;
    n = 0;
    do begin
      @(posedge i_mclk);
      go <= 1'b0;
      #1;
      {ab, rl, md} = {ab | abort_lun, rl | release_lun, md | mode_restore};
      {dn, pg, sd, sb} = {dn | done, pg | purge, sd | stop_data, sb | st_block};
      n = n + 1;
    end while (done !== 1'b1 && n < 400);
    chk(done, 1'b1);
    chk(rtag, tg);
    chk(rcode, rc);
    chk({rb[0], rb[1]}, {8'h83, 8'h03});
    chk({rb[2], rb[3], rb[4]}, {tg, rc});
    chk(rbn, 5);
    chk(rpath, pt);
    chk({qb[0], qb[1], qb[2], qb[3]}, {8'h83, pc, tg});
    chk({qb[4], qb[5], qb[6], qb[7]}, pt);
    chk(qbn, (pc == 8'h33) ? 8 : 9);
    if (pc != 8'h33) chk(qb[8], ln);
    @(posedge i_mclk);
    #1;
    chk(busy, 1'b0);
  endtask : run
  // keeps data or status outstanding, so the reset must wait before acting
  task automatic hold(input logic [7:0] m, input logic b, input logic [7:0] fl);
    @(posedge i_mclk);
    pend <= m;
    sbusy <= b;
    repeat (30) @(posedge i_mclk);
    #2;
    chk(dn, 1'b0);
    chk(flush_lun, fl);
    chk(ab, 8'h00);
    @(posedge i_mclk);
    pend <= 8'h00;
    sbusy <= 1'b0;
  endtask : hold
  // watchdog: whole sequence needs well under 1500 cycles
  initial begin
    #(3000 * 100);
    err_count = err_count + 1;
    results();
  end
  initial begin
    repeat (20) @(posedge i_mclk);
    i_nrst <= 1'b1;
    aca_pulse(8'h02, 8'h04);
    aca_pulse(8'h00, 8'h08);
    aca_pulse(8'h01, 8'h04);
    @(posedge i_mclk);
    #1;
    chk(aca, 32'h00040408);
    run(8'h34, 8'h02, 8'h00, 16'h1234, 32'h0a0b0c0d);
    chk(aca, 32'h00040008);
    chk({ab, rl, md, ua}, 28'h0);
    run(8'h34, 8'h02, 8'h20, 16'hfe01, 32'h80000001);
    run(8'h34, 8'h07, 8'hff, 16'h0001, 32'h00000000);
    chk(aca, 32'h00040008);
    fork
      run(8'h35, 8'h03, 8'h00, 16'h5a5a, 32'hffffffff);
      hold(8'h08, 1'b0, 8'h08);
    join
    chk({ab, rl, md}, 24'h080808);
    chk(aca, 32'h00040000);
    chk(ua, 4'hf);
    chk({pg, sd}, 2'b11);
    run(8'h35, 8'h07, 8'hff, 16'h0707, 32'h12345678);
    chk({ab, rl, md}, 24'h0);
    fork
      run(8'h33, 8'h00, 8'h00, 16'hc3c3, 32'h5555aaaa);
      hold(8'h81, 1'b1, 8'hff);
    join
    chk({ab, rl, md}, 24'hffffff);
    chk(aca, 32'h0);
    chk({sb, ua}, 5'h1f);
    run(8'h34, 8'h00, 8'h20, 16'h0100, 32'h00ff00ff);
    results();
  end
endmodule : testbench
`default_nettype wire
